// [clear_ops.sv]
// Purpose: decode and execute the register-clear and watchdog-restart instructions
// Assumes: instruction word is stable for a whole four-phase cycle
// Notes: other opcodes leave every write and restart strobe low
//
// Contract
// - register clear writes zero to the addressed register and sets the zero flag.
// - register clear is the 16-bit word 0110 101a followed by an 8-bit address.
// - with the bank bit low the fixed access bank is used and the bank select is ignored.
// - with the bank bit high the bank select register forms the upper address.
// - watchdog restart clears the watchdog counter and its postscaler.
// - watchdog restart sets the low-active time-out and power-down bits to one only.
`timescale 1ns/10ps
module clear_ops
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic [3:0] bank_select_reg,
  input wire logic [4:0] status_in,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic [4:0] status_out,
  output logic status_we,
  output logic watchdog_counter_clear,
  output logic postscaler_clear,
  output logic timeout_status_n,
  output logic powerdown_status_n,
  output logic cycle_phase_decode
);
  import clr_pkg::*;

  // ************************************************************
  // instruction cycle phase
  // ************************************************************
  logic [1:0] phase;
  logic write_phase;

  phase_counter u_phase
  (
    .clk(clk),
    .nrst(nrst),
    .phase(phase)
  );

  always_comb
  begin
    // effects land in the last phase so the next cycle sees them
    write_phase = (phase == phase_write);
  end

  // ************************************************************
  // opcode decode
  // ************************************************************
  typedef enum logic [2:0]
  {
    op_none = 3'b001,
    op_clear_file = 3'b010,
    op_restart = 3'b100
  } op_class_e;

  op_class_e op_class;
  logic is_clear_file_op;
  logic is_watchdog_restart_op;
  logic bank_choice;
  logic [3:0] eff_bank;
  logic [7:0] file_addr;

  always_comb
  begin
    is_clear_file_op = instr_valid && (instr_word[15:9] == clr_file_opcode);
    is_watchdog_restart_op = instr_valid && (instr_word == wdt_restart_word);
    if (is_clear_file_op)
      op_class = op_clear_file;
    else if (is_watchdog_restart_op)
      op_class = op_restart;
    else
      op_class = op_none;
    bank_choice = instr_word[8];
    file_addr = instr_word[7:0];
    if (bank_choice)
      eff_bank = bank_select_reg;
    else
      eff_bank = access_bank;
  end

  // ************************************************************
  // data memory write port
  // ************************************************************
  logic [11:0] next_mem_addr;
  logic [7:0] next_mem_wdata;
  logic next_mem_we;

  always_comb
  begin
    // address follows the word every clock, only the strobe qualifies it
    next_mem_addr = {eff_bank, file_addr};
    next_mem_wdata = clear_value;
    next_mem_we = 1'b0;
    if (write_phase && (op_class == op_clear_file))
      next_mem_we = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mem_addr <= addr_reset;
      mem_wdata <= clear_value;
      mem_we <= 1'b0;
    end
    else
    begin
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      mem_we <= next_mem_we;
    end
  end

  // ************************************************************
  // arithmetic status flags
  // ************************************************************
  logic [4:0] next_status_out;
  logic next_status_we;

  always_comb
  begin
    // carry, digit carry, overflow and negative pass through untouched
    next_status_out = status_in;
    next_status_we = 1'b0;
    if (write_phase && (op_class == op_clear_file))
    begin
      next_status_out[flag_zero] = 1'b1;
      next_status_we = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      status_out <= status_reset;
      status_we <= 1'b0;
    end
    else
    begin
      status_out <= next_status_out;
      status_we <= next_status_we;
    end
  end

  // ************************************************************
  // watchdog restart strobes
  // ************************************************************
  logic next_wdt_clear;
  logic next_post_clear;

  always_comb
  begin
    // counter and postscaler always restart together
    next_wdt_clear = 1'b0;
    next_post_clear = 1'b0;
    if (write_phase && (op_class == op_restart))
    begin
      next_wdt_clear = 1'b1;
      next_post_clear = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      watchdog_counter_clear <= 1'b0;
      postscaler_clear <= 1'b0;
    end
    else
    begin
      watchdog_counter_clear <= next_wdt_clear;
      postscaler_clear <= next_post_clear;
    end
  end

  // ************************************************************
  // low-active time-out and power-down status
  // ************************************************************
  logic next_timeout_n;
  logic next_powerdown_n;

  always_comb
  begin
    // this block only sets them; clearing belongs to sleep and time-out logic
    next_timeout_n = timeout_status_n;
    next_powerdown_n = powerdown_status_n;
    if (write_phase && (op_class == op_restart))
    begin
      next_timeout_n = 1'b1;
      next_powerdown_n = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      timeout_status_n <= status_n_reset;
      powerdown_status_n <= status_n_reset;
    end
    else
    begin
      timeout_status_n <= next_timeout_n;
      powerdown_status_n <= next_powerdown_n;
    end
  end

  // ************************************************************
  // decode phase strobe
  // ************************************************************
  logic next_phase_decode;

  always_comb
  begin
    // high in the clock that starts a new instruction cycle
    next_phase_decode = write_phase;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cycle_phase_decode <= 1'b0;
    else
      cycle_phase_decode <= next_phase_decode;
  end
endmodule : clear_ops

// [clr_pkg.sv]
// Purpose: constants for the clear-instruction decode and execute block
// Assumes: 16-bit program words, 8-bit data memory, four-phase instruction cycle
// Notes: phase numbering 0..3 stands for decode, read, process, write
package clr_pkg;
  localparam logic [6:0] clr_file_opcode = 7'h35;
  localparam logic [15:0] wdt_restart_word = 16'h0004;
  localparam logic [3:0] access_bank = 4'h0;
  localparam logic [3:0] bank_select_reset = 4'h0;
  localparam logic [7:0] clear_value = 8'h00;
  localparam logic [1:0] phase_reset = 2'h0;
  localparam logic [1:0] phase_write = 2'h3;
  localparam logic [4:0] status_reset = 5'h00;
  localparam logic [11:0] addr_reset = 12'h000;
  localparam logic status_n_reset = 1'b1;
  localparam int flag_carry = 0;
  localparam int flag_digit = 1;
  localparam int flag_zero = 2;
  localparam int flag_overflow = 3;
  localparam int flag_negative = 4;
endpackage : clr_pkg

// [phase_counter.sv]
// Purpose: four-phase instruction cycle counter
// Assumes: one instruction cycle is four core clocks
// Notes: phase 0 decode, 3 write
`timescale 1ns/10ps
module phase_counter
(
  input wire logic clk,
  input wire logic nrst,
  output logic [1:0] phase
);
  import clr_pkg::*;

  logic [1:0] next_phase;

  always_comb
  begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      phase <= phase_reset;
    else
      phase <= next_phase;
  end
endmodule : phase_counter

// [clear_ops_sva.sv]
// Purpose: port checks for the clear block
// Assumes: one clock, synchronous low reset
// Notes: bound to clear_ops at the foot
`timescale 1ns/10ps
module clear_ops_sva (
  input logic clk,
  input logic nrst,
  input logic [15:0] instr_word,
  input logic instr_valid,
  input logic [3:0] bank_select_reg,
  input logic [4:0] status_in,
  input logic [11:0] mem_addr,
  input logic [7:0] mem_wdata,
  input logic mem_we,
  input logic [4:0] status_out,
  input logic status_we,
  input logic watchdog_counter_clear,
  input logic postscaler_clear,
  input logic timeout_status_n,
  input logic powerdown_status_n,
  input logic cycle_phase_decode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_we; mem_we |-> status_we && cycle_phase_decode && mem_wdata == 8'h00; endproperty
  a_we: assert property (p_we) else $error("bad clear write");
  property p_st; status_we |-> status_out == ($past(status_in) | 5'h04); endproperty
  a_st: assert property (p_st) else $error("bad status");
  property p_dec; cycle_phase_decode && $past(instr_valid)
    && $past(instr_word[15:9]) == 7'h35 |-> mem_we; endproperty
  a_dec: assert property (p_dec) else $error("clear missed");
  property p_a0; mem_we && !$past(instr_word[8]) |-> mem_addr == {4'h0, $past(instr_word[7:0])};
  endproperty
  a_a0: assert property (p_a0) else $error("bad access bank");
  property p_a1; mem_we && $past(instr_word[8])
    |-> mem_addr == {$past(bank_select_reg), $past(instr_word[7:0])}; endproperty
  a_a1: assert property (p_a1) else $error("bad banked addr");
  property p_wd; watchdog_counter_clear |-> postscaler_clear && cycle_phase_decode
    && $past(instr_valid) && $past(instr_word) == 16'h0004; endproperty
  a_wd: assert property (p_wd) else $error("bad restart");
  property p_fl; timeout_status_n && powerdown_status_n; endproperty
  a_fl: assert property (p_fl) else $error("status bit low");
  property p_cy; cycle_phase_decode |=> !cycle_phase_decode [*3] ##1 cycle_phase_decode; endproperty
  a_cy: assert property (p_cy) else $error("bad cycle");
  property p_wgo; cycle_phase_decode && $past(instr_valid) && $past(instr_word) == 16'h0004
    |-> watchdog_counter_clear && postscaler_clear && !status_we; endproperty
  a_wgo: assert property (p_wgo) else $error("restart missed");
  property p_ref; mem_we |-> $past(instr_valid) && $past(instr_word[15:9]) == 7'h35; endproperty
  a_ref: assert property (p_ref) else $error("clear without opcode");
endmodule : clear_ops_sva
bind clear_ops clear_ops_sva chk (.*);

// [mem_model.sv]
// Purpose: data memory beside the clear block
// Assumes: one write port, async read
// Notes: preset to 5a so a clear shows
`timescale 1ns/10ps
module mem_model (
  input logic clk,
  input logic mem_we,
  input logic [11:0] mem_addr,
  input logic [7:0] mem_wdata,
  input logic [11:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] m [4096];
  initial foreach (m[i]) m[i] = 8'h5a;
  always @(posedge clk) if (mem_we) m[mem_addr] <= mem_wdata;
  assign rdata = m[raddr];
endmodule : mem_model

// [clear_ops_tb_top.sv]
// Purpose: bench for the clear block
// Assumes: 10 MHz clock, inputs driven on the falling edge
// Notes: one instruction per four clocks
`timescale 1ns/10ps
module clear_ops_tb_top;
  logic clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0, mem_we, status_we, cycle_phase_decode;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_reg = 4'h0;
  logic [4:0] status_in = 5'h1b, status_out;
  logic [11:0] mem_addr, raddr = 12'h312;
  logic [7:0] mem_wdata, rdata;
  logic watchdog_counter_clear, postscaler_clear, timeout_status_n, powerdown_status_n;
  int n_mismatch = 0, total_checks = 0;
  clear_ops uut
  (
    .clk(clk), .nrst(nrst), .instr_word(instr_word), .instr_valid(instr_valid),
    .bank_select_reg(bank_select_reg), .status_in(status_in), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .status_out(status_out), .status_we(status_we),
    .watchdog_counter_clear(watchdog_counter_clear), .postscaler_clear(postscaler_clear),
    .timeout_status_n(timeout_status_n), .powerdown_status_n(powerdown_status_n),
    .cycle_phase_decode(cycle_phase_decode)
  );
  mem_model mdl
  (
    .clk(clk), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .raddr(raddr), .rdata(rdata)
  );
  always #50 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic run(input logic [15:0] w, input logic [3:0] b, input logic v);
    int i;
    for (i = 0; i < 9 && cycle_phase_decode !== 1'b1; i++) @(negedge clk);
    if (cycle_phase_decode !== 1'b1)
    begin
      n_mismatch++;
      close_out();
    end
    else
    begin
      instr_word = w;
      bank_select_reg = b;
      instr_valid = v;
      repeat (4) @(negedge clk);
    end
  endtask : run
  task automatic t_clear;
    run(16'h6b12, 4'h3, 1'b1);
    chk(16'({mem_we, status_we, mem_addr}), 16'h3312);
    chk(16'(status_out), 16'h001f);
    run(16'h6a34, 4'h5, 1'b1);
    chk(16'({mem_we, mem_addr}), 16'h1034);
    chk(16'(rdata), 16'h0000);
    $display("clear test done");
  endtask : t_clear
  task automatic t_wdt;
    run(16'h0004, 4'h0, 1'b1);
    chk(16'({watchdog_counter_clear, postscaler_clear, timeout_status_n,
      powerdown_status_n, mem_we, status_we}), 16'h003c);
    run(16'h0005, 4'h0, 1'b1);
    chk(16'(watchdog_counter_clear), 16'h0000);
    $display("restart test done");
  endtask : t_wdt
  task automatic t_refuse;
    run(16'h6c12, 4'h3, 1'b1);
    chk(16'(mem_we), 16'h0000);
    run(16'h6b12, 4'h3, 1'b0);
    chk(16'(mem_we), 16'h0000);
    $display("refuse test done");
  endtask : t_refuse
  task automatic t_reset;
    run(16'h6b12, 4'h3, 1'b1);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'({mem_we, status_we, watchdog_counter_clear, postscaler_clear,
      cycle_phase_decode}), 16'h0000);
    chk(16'(mem_addr), 16'h0000);
    chk(16'({status_out, timeout_status_n, powerdown_status_n}), 16'h0003);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    chk(16'(cycle_phase_decode), 16'h0000);
    @(negedge clk);
    chk(16'({cycle_phase_decode, mem_we, mem_addr}), 16'h3312);
    $display("reset test done");
  endtask : t_reset
  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_clear();
    t_wdt();
    t_refuse();
    t_reset();
    close_out();
  end
endmodule : clear_ops_tb_top
